// ### hdl/serial_bit_engine.sv
`timescale 1ns/1ns
module serial_bit_engine #(
  parameter int CNT_W = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input serial_pkg::bit_cmd_e cmd,
  input wire logic tx_bit,
  input wire logic [CNT_W-1:0] quarter_cycles,
  input wire logic scl_level,
  input wire logic sda_level,
  output logic ready,
  output logic done,
  output logic rx_bit,
  output logic scl_low,
  output logic sda_low
);
  import serial_pkg::*;
  logic active, next_active;
  logic [1:0] phase, next_phase;
  logic [CNT_W-1:0] count, next_count;
  bit_cmd_e cur, next_cur;
  logic bit_val, next_bit_val;
  logic next_rx;
  logic hold_scl, next_hold_scl;
  logic hold_sda, next_hold_sda;
  logic scl_rel;
  logic sda_drv;
  // ----------------------------------------
  // Four-phase bit sequencer
  // ----------------------------------------
  always_comb begin
    unique case (cur)
      BIT_START: begin
        scl_rel = (phase == 2'd1) || (phase == 2'd2);
        sda_drv = phase[1];
      end
      BIT_STOP: begin
        scl_rel = (phase != 2'd0);
        sda_drv = (phase != 2'd3);
      end
      BIT_DATA: begin
        scl_rel = (phase == 2'd1) || (phase == 2'd2);
        sda_drv = !bit_val;
      end
      default: begin
        scl_rel = 1'b1;
        sda_drv = 1'b0;
      end
    endcase
    scl_low = active ? !scl_rel : hold_scl;
    sda_low = active ? sda_drv : hold_sda;
  end
  always_comb begin
    next_active = active;
    next_phase = phase;
    next_count = count;
    next_cur = cur;
    next_bit_val = bit_val;
    next_rx = rx_bit;
    next_hold_scl = hold_scl;
    next_hold_sda = hold_sda;
    done = 1'b0;
    ready = !active;
    if (!active) begin
      if (start) begin
        next_active = 1'b1;
        next_phase = 2'd0;
        next_count = quarter_cycles;
        next_cur = cmd;
        next_bit_val = tx_bit;
      end
    end else if (!(scl_rel && !scl_level)) begin
      // A target holding the clock low stretches the high phases
      if (count > 1) begin
        next_count = count - 1'b1;
      end else begin
        next_count = quarter_cycles;
        next_phase = phase + 2'd1;
        if (phase == 2'd2) begin
          next_rx = sda_level;
        end
        if (phase == 2'd3) begin
          next_active = 1'b0;
          done = 1'b1;
          next_hold_scl = (cur != BIT_STOP);
          next_hold_sda = sda_drv;
        end
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      active <= 1'b0;
      phase <= 2'd0;
      count <= '0;
      cur <= BIT_DATA;
      bit_val <= 1'b1;
      rx_bit <= 1'b1;
      hold_scl <= 1'b0;
      hold_sda <= 1'b0;
    end else begin
      active <= next_active;
      phase <= next_phase;
      count <= next_count;
      cur <= next_cur;
      bit_val <= next_bit_val;
      rx_bit <= next_rx;
      hold_scl <= next_hold_scl;
      hold_sda <= next_hold_sda;
    end
  end
endmodule // serial_bit_engine

// ### hdl/serial_cycle_control.sv
`timescale 1ns/1ns
`include "serial_regs.svh"
// ----------------------------------------
// What this block does
// (RULE_01) Target address write launches one transaction
// (RULE_02) Bits 7:1 hold seven-bit target address
// (RULE_03) Bit 0 picks write or read
// (RULE_04) Control bit 7 skips word address
// (RULE_05) Control bit 6 reads zero
// (RULE_06) Status bit 5 shows software cycle busy
// (RULE_07) Status bit 4 shows loader busy
// (RULE_08) Control bit 3 turns pins into serial
// (RULE_09) Found EEPROM sets present bit; writable
// (RULE_10) Detect once per platform reset release
// (RULE_11) Present bit zero skips default load
// (RULE_12) Control bit 2 selects fast test clock
// (RULE_13) Software cycle error sticks until cleared
// (RULE_14) Load error sticks until cleared
// (RULE_15) Fields reset only on fundamental reset
// (RULE_16) Software loads data byte before launch
// (RULE_17) Read byte delivered before busy clears
// (RULE_18) Word address comes from index byte
// (RULE_19) Software waits for busy before relaunch
// (RULE_20) Any missing acknowledge is an error; a missing acknowledge on the loader's probe sets neither error bit
// ----------------------------------------
module serial_cycle_control #(
  parameter logic [6:0] EEPROM_DEV_ADDR = 7'h50,
  parameter int LOAD_COUNT = 4,
  parameter int CNT_W = 8
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic PLATFORM_RESET_N,
  input wire logic GLOBAL_RESET_N,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR_EN,
  input wire logic [7:0] REG_WR_DATA,
  input wire logic REG_RD_EN,
  output logic [7:0] REG_RD_DATA,
  input wire logic [7:0] DATA_BYTE,
  input wire logic [7:0] INDEX_BYTE,
  output logic [7:0] RX_BYTE,
  output logic RX_SW_STROBE,
  output logic RX_LOAD_STROBE,
  output logic [7:0] LOAD_INDEX,
  input wire logic GP_FOUR_OUT,
  input wire logic GP_FOUR_OE,
  input wire logic GP_FIVE_OUT,
  input wire logic GP_FIVE_OE,
  input wire logic SHARED_PIN_FOUR_IN,
  output logic SHARED_PIN_FOUR_OUT,
  output logic SHARED_PIN_FOUR_OE,
  input wire logic SHARED_PIN_FIVE_IN,
  output logic SHARED_PIN_FIVE_OUT,
  output logic SHARED_PIN_FIVE_OE
);
  import serial_pkg::*;
  logic platform_reset_n, global_reset_n, scl_level, sda_level, fundamental_reset_n;
  logic [7:0] target_addr, next_target_addr;
  logic address_phase_select, next_address_phase_select;
  logic eeprom_present_enable, next_eeprom_present_enable;
  logic fast_test_clock_select, next_fast_test_clock_select;
  logic software_cycle_error, next_software_cycle_error;
  logic eeprom_load_error, next_eeprom_load_error;
  txn_state_e state, next_state;
  load_state_e ld_state, next_ld_state;
  logic [3:0] bit_cnt, next_bit_cnt;
  logic [7:0] shifter, next_shifter;
  logic [6:0] txn_dev, next_txn_dev;
  logic [7:0] txn_word, next_txn_word;
  logic [7:0] txn_data, next_txn_data;
  logic txn_rd, next_txn_rd, txn_skip, next_txn_skip;
  logic txn_loader, next_txn_loader, txn_probe, next_txn_probe;
  logic txn_err, next_txn_err, sw_pending, next_sw_pending;
  logic [7:0] ld_index, next_ld_index;
  logic [7:0] next_rx_byte;
  logic next_rx_sw_strobe, next_rx_load_strobe;
  logic detect_pending, next_detect_pending, platform_reset_n_prev, next_platform_reset_n_prev;
  logic [7:0] next_rd_data;
  logic next_four_out, next_four_oe, next_five_out, next_five_oe;
  logic wr_target, wr_ctrl, sw_busy, load_busy, pins_serial, seq_rst;
  logic txn_done, probe_ack, ld_start;
  logic eng_start, eng_tx, eng_ready, eng_done, eng_rx, eng_scl_low, eng_sda_low;
  bit_cmd_e eng_cmd;
  logic [CNT_W-1:0] quarter;
  // ----------------------------------------
  // Pin and reset synchronisers
  // ----------------------------------------
  serial_sync2 #(.W(4)) u_sync (
    .clk(CLK),
    .rst(RST),
    .d({PLATFORM_RESET_N, GLOBAL_RESET_N, SHARED_PIN_FOUR_IN, SHARED_PIN_FIVE_IN}),
    .q({platform_reset_n, global_reset_n, scl_level, sda_level})
  );
  assign fundamental_reset_n = platform_reset_n && global_reset_n; // [RULE_15]
  assign seq_rst = RST || !fundamental_reset_n;
  assign wr_target = REG_WR_EN && (REG_ADDR == `TARGET_ADDR_OFFSET);
  assign wr_ctrl = REG_WR_EN && (REG_ADDR == `CTRL_STATUS_OFFSET);
  assign sw_busy = sw_pending || ((state != S_IDLE) && !txn_loader); // [RULE_06]
  assign load_busy = (ld_state != LD_OFF); // [RULE_07]
  assign pins_serial = eeprom_present_enable || load_busy; // [RULE_08]
  // Fast rate is test only; the count floors at one cycle per phase
  assign quarter = fast_test_clock_select ? CNT_W'(`FAST_QUARTER_CYC) : CNT_W'(`NORMAL_QUARTER_CYC); // [RULE_12]
  serial_bit_engine #(.CNT_W(CNT_W)) u_engine (
    .clk(CLK),
    .rst(seq_rst),
    .start(eng_start),
    .cmd(eng_cmd),
    .tx_bit(eng_tx),
    .quarter_cycles(quarter),
    .scl_level(scl_level),
    .sda_level(sda_level),
    .ready(eng_ready),
    .done(eng_done),
    .rx_bit(eng_rx),
    .scl_low(eng_scl_low),
    .sda_low(eng_sda_low)
  );
  // ----------------------------------------
  // Sticky control and status fields
  // ----------------------------------------
  always_comb begin
    next_target_addr = target_addr;
    next_address_phase_select = address_phase_select;
    next_eeprom_present_enable = eeprom_present_enable;
    next_fast_test_clock_select = fast_test_clock_select;
    next_software_cycle_error = software_cycle_error;
    next_eeprom_load_error = eeprom_load_error;
    if (wr_target) begin
      next_target_addr = REG_WR_DATA; // [RULE_02] [RULE_03]
    end
    if (wr_ctrl) begin
      next_address_phase_select = REG_WR_DATA[`ADDR_PHASE_BIT]; // [RULE_04]
      next_eeprom_present_enable = REG_WR_DATA[`PRESENT_BIT]; // [RULE_09]
      next_fast_test_clock_select = REG_WR_DATA[`FAST_CLOCK_BIT]; // [RULE_12]
      if (REG_WR_DATA[`SW_ERROR_BIT]) begin
        next_software_cycle_error = 1'b0;
      end
      if (REG_WR_DATA[`LOAD_ERROR_BIT]) begin
        next_eeprom_load_error = 1'b0;
      end
    end
    // Hardware sets come last so an event beats a same-cycle clear
    if (probe_ack) begin
      next_eeprom_present_enable = 1'b1; // [RULE_09]
    end
    if (txn_done && txn_err && !txn_loader) begin
      next_software_cycle_error = 1'b1; // [RULE_13]
    end
    if (txn_done && txn_err && txn_loader && !txn_probe) begin
      next_eeprom_load_error = 1'b1; // [RULE_14]
    end
  end
  always_ff @(posedge CLK) begin
    if (!fundamental_reset_n) begin // [RULE_15]
      target_addr <= `TARGET_ADDR_RESET;
      address_phase_select <= 1'b0;
      eeprom_present_enable <= 1'b0;
      fast_test_clock_select <= 1'b0;
      software_cycle_error <= 1'b0;
      eeprom_load_error <= 1'b0;
    end else begin
      target_addr <= next_target_addr;
      address_phase_select <= next_address_phase_select;
      eeprom_present_enable <= next_eeprom_present_enable;
      fast_test_clock_select <= next_fast_test_clock_select;
      software_cycle_error <= next_software_cycle_error;
      eeprom_load_error <= next_eeprom_load_error;
    end
  end
  // ----------------------------------------
  // Detection trigger
  // ----------------------------------------
  // Survives a global reset still held when the platform reset lifts
  assign ld_start = detect_pending && (ld_state == LD_OFF) && fundamental_reset_n;
  always_comb begin
    next_platform_reset_n_prev = platform_reset_n;
    next_detect_pending = (detect_pending || (platform_reset_n && !platform_reset_n_prev)) && !ld_start; // [RULE_10]
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      platform_reset_n_prev <= 1'b0;
      detect_pending <= 1'b0;
    end else begin
      platform_reset_n_prev <= next_platform_reset_n_prev;
      detect_pending <= next_detect_pending;
    end
  end
  // ----------------------------------------
  // Transaction and loader sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_ld_state = ld_state;
    next_bit_cnt = bit_cnt;
    next_shifter = shifter;
    next_txn_dev = txn_dev;
    next_txn_word = txn_word;
    next_txn_data = txn_data;
    next_txn_rd = txn_rd;
    next_txn_skip = txn_skip;
    next_txn_loader = txn_loader;
    next_txn_probe = txn_probe;
    next_txn_err = txn_err;
    next_sw_pending = sw_pending;
    next_ld_index = ld_index;
    next_rx_byte = RX_BYTE;
    next_rx_sw_strobe = 1'b0;
    next_rx_load_strobe = 1'b0;
    txn_done = 1'b0;
    probe_ack = 1'b0;
    eng_start = (state != S_IDLE) && eng_ready;
    eng_cmd = BIT_DATA;
    eng_tx = (state == S_RDATA) || bit_cnt[3] || shifter[7];
    if ((state == S_START) || (state == S_RESTART)) begin
      eng_cmd = BIT_START;
    end else if (state == S_STOP) begin
      eng_cmd = BIT_STOP;
    end
    if (wr_target && !sw_busy) begin
      next_sw_pending = 1'b1; // [RULE_01] [RULE_19]
    end
    if (ld_start) begin
      next_ld_state = LD_PROBE;
    end
    if (state == S_IDLE) begin
      next_bit_cnt = 4'd0;
      next_txn_err = 1'b0;
      if ((ld_state == LD_PROBE) || (ld_state == LD_READ)) begin
        next_txn_dev = EEPROM_DEV_ADDR;
        next_txn_rd = (ld_state == LD_READ);
        next_txn_probe = (ld_state == LD_PROBE);
        next_txn_skip = 1'b0;
        next_txn_word = ld_index;
        next_txn_loader = 1'b1;
        next_ld_state = (ld_state == LD_PROBE) ? LD_PROBE_WAIT : LD_READ_WAIT;
        next_state = S_START;
      end else if (sw_pending) begin
        next_txn_dev = target_addr[7:1]; // [RULE_02]
        next_txn_rd = target_addr[`DIR_BIT]; // [RULE_03]
        next_txn_skip = address_phase_select; // [RULE_04]
        next_txn_word = INDEX_BYTE; // [RULE_18]
        next_txn_data = DATA_BYTE; // [RULE_16]
        next_txn_probe = 1'b0;
        next_txn_loader = 1'b0;
        next_sw_pending = 1'b0;
        next_state = S_START; // [RULE_01]
      end
    end else if (eng_done) begin
      unique case (state)
        S_START: next_state = (txn_rd && txn_skip) ? S_RDEV : S_DEV; // [RULE_04]
        S_RESTART: next_state = S_RDEV;
        S_STOP: begin
          next_state = S_IDLE;
          txn_done = 1'b1;
        end
        default: begin
          if (bit_cnt != 4'd8) begin
            next_shifter = {shifter[6:0], eng_rx};
            next_bit_cnt = bit_cnt + 4'd1;
          end else begin
            next_bit_cnt = 4'd0;
            if ((state != S_RDATA) && eng_rx) begin
              next_txn_err = 1'b1; // [RULE_20]
              next_state = S_STOP;
            end else begin
              unique case (state)
                S_DEV: begin
                  probe_ack = txn_probe;
                  next_state = txn_probe ? S_STOP : (txn_skip ? S_WDATA : S_WORD);
                end
                S_WORD: next_state = txn_rd ? S_RESTART : S_WDATA;
                S_RDEV: next_state = S_RDATA;
                S_WDATA: next_state = S_STOP;
                S_RDATA: begin
                  next_rx_byte = shifter; // [RULE_17]
                  next_rx_sw_strobe = !txn_loader;
                  next_rx_load_strobe = txn_loader;
                  next_state = S_STOP;
                end
                default: next_state = S_STOP;
              endcase
            end
          end
        end
      endcase
    end
    if (next_state != state) begin
      unique case (next_state)
        S_DEV: next_shifter = {txn_dev, 1'b0};
        S_RDEV: next_shifter = {txn_dev, 1'b1};
        S_WORD: next_shifter = txn_word; // [RULE_18]
        S_WDATA: next_shifter = txn_data;
        default: next_shifter = shifter;
      endcase
    end
    if (txn_done && txn_loader) begin
      if (ld_state == LD_PROBE_WAIT) begin
        next_ld_index = 8'h00;
        next_ld_state = eeprom_present_enable ? LD_READ : LD_OFF; // [RULE_11]
      end else if (txn_err || (ld_index == 8'(LOAD_COUNT - 1))) begin
        next_ld_state = LD_OFF;
      end else begin
        next_ld_index = ld_index + 8'h01;
        next_ld_state = LD_READ;
      end
    end
  end
  always_ff @(posedge CLK) begin
    if (seq_rst) begin
      state <= S_IDLE;
      ld_state <= LD_OFF;
      bit_cnt <= 4'd0;
      shifter <= 8'h00;
      txn_dev <= 7'h00;
      txn_word <= 8'h00;
      txn_data <= 8'h00;
      txn_rd <= 1'b0;
      txn_skip <= 1'b0;
      txn_loader <= 1'b0;
      txn_probe <= 1'b0;
      txn_err <= 1'b0;
      sw_pending <= 1'b0;
      ld_index <= 8'h00;
      RX_BYTE <= 8'h00;
      RX_SW_STROBE <= 1'b0;
      RX_LOAD_STROBE <= 1'b0;
    end else begin
      state <= next_state;
      ld_state <= next_ld_state;
      bit_cnt <= next_bit_cnt;
      shifter <= next_shifter;
      txn_dev <= next_txn_dev;
      txn_word <= next_txn_word;
      txn_data <= next_txn_data;
      txn_rd <= next_txn_rd;
      txn_skip <= next_txn_skip;
      txn_loader <= next_txn_loader;
      txn_probe <= next_txn_probe;
      txn_err <= next_txn_err;
      sw_pending <= next_sw_pending;
      ld_index <= next_ld_index;
      RX_BYTE <= next_rx_byte;
      RX_SW_STROBE <= next_rx_sw_strobe;
      RX_LOAD_STROBE <= next_rx_load_strobe;
    end
  end
  assign LOAD_INDEX = txn_word;
  // ----------------------------------------
  // Read-back and pin drivers
  // ----------------------------------------
  always_comb begin
    next_rd_data = REG_RD_DATA;
    if (REG_RD_EN) begin
      if (REG_ADDR == `TARGET_ADDR_OFFSET) begin
        next_rd_data = target_addr;
      end else if (REG_ADDR == `CTRL_STATUS_OFFSET) begin
        next_rd_data = {address_phase_select, 1'b0, sw_busy, load_busy, // [RULE_05] [RULE_06] [RULE_07]
                        eeprom_present_enable, fast_test_clock_select, software_cycle_error, eeprom_load_error};
      end else begin
        next_rd_data = 8'h00;
      end
    end
    // Open drain: serial mode only ever pulls low
    next_four_out = pins_serial ? 1'b0 : GP_FOUR_OUT; // [RULE_08]
    next_four_oe = pins_serial ? eng_scl_low : GP_FOUR_OE;
    next_five_out = pins_serial ? 1'b0 : GP_FIVE_OUT;
    next_five_oe = pins_serial ? eng_sda_low : GP_FIVE_OE;
  end
  always_ff @(posedge CLK) begin
    if (RST) begin
      REG_RD_DATA <= 8'h00;
      SHARED_PIN_FOUR_OUT <= 1'b0;
      SHARED_PIN_FOUR_OE <= 1'b0;
      SHARED_PIN_FIVE_OUT <= 1'b0;
      SHARED_PIN_FIVE_OE <= 1'b0;
    end else begin
      REG_RD_DATA <= next_rd_data;
      SHARED_PIN_FOUR_OUT <= next_four_out;
      SHARED_PIN_FOUR_OE <= next_four_oe;
      SHARED_PIN_FIVE_OUT <= next_five_out;
      SHARED_PIN_FIVE_OE <= next_five_oe;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (seq_rst);
  launch_on_write_a: assert property ( // [RULE_01]
    wr_target && !sw_busy && state == S_IDLE && ld_state == LD_OFF && !detect_pending
    |=> sw_pending ##1 (state == S_START && !txn_loader)) else $error("write did not launch");
  dev_byte_load_a: assert property ( // [RULE_02]
    $changed(state) && state == S_DEV |-> shifter == {txn_dev, 1'b0}) else $error("bad address byte");
  read_direct_a: assert property ( // [RULE_03]
    state == S_START && eng_done && txn_rd && txn_skip |=> state == S_RDEV) else $error("bad read route");
  word_phase_a: assert property ( // [RULE_04]
    $changed(state) && state == S_WORD |-> !txn_skip && shifter == txn_word) else $error("bad word phase");
  reserved_zero_a: assert property ( // [RULE_05]
    REG_RD_EN && REG_ADDR == `CTRL_STATUS_OFFSET |=> !REG_RD_DATA[`RESERVED_BIT]) else $error("reserved set");
  busy_read_a: assert property ( // [RULE_06]
    REG_RD_EN && REG_ADDR == `CTRL_STATUS_OFFSET |=> REG_RD_DATA[`SW_BUSY_BIT] == $past(sw_busy))
    else $error("busy bit wrong");
  load_busy_read_a: assert property ( // [RULE_07]
    REG_RD_EN && REG_ADDR == `CTRL_STATUS_OFFSET |=> REG_RD_DATA[`LOAD_BUSY_BIT] == $past(load_busy))
    else $error("load busy wrong");
  gpio_pass_a: assert property ( // [RULE_08]
    !pins_serial |=> SHARED_PIN_FOUR_OE == $past(GP_FOUR_OE) && SHARED_PIN_FIVE_OUT == $past(GP_FIVE_OUT))
    else $error("pins not passed through");
  probe_present_a: assert property ( // [RULE_09]
    probe_ack |=> eeprom_present_enable) else $error("present not set");
  skip_load_a: assert property ( // [RULE_11]
    ld_state == LD_PROBE_WAIT && txn_done && !eeprom_present_enable |=> ld_state == LD_OFF)
    else $error("load not skipped");
  error_sticky_a: assert property ( // [RULE_13]
    software_cycle_error && !(wr_ctrl && REG_WR_DATA[`SW_ERROR_BIT]) |=> software_cycle_error)
    else $error("error bit dropped");
  nack_error_a: assert property ( // [RULE_20]
    eng_done && bit_cnt == 4'd8 && state inside {S_DEV, S_WORD, S_WDATA, S_RDEV} && eng_rx
    |=> state == S_STOP && txn_err) else $error("nack not flagged");
  read_before_idle_a: assert property ( // [RULE_17]
    RX_SW_STROBE |-> state == S_STOP && sw_busy) else $error("read byte late");
  sw_write_c: cover property (txn_done && !txn_loader && !txn_rd && !txn_err);
  sw_read_c: cover property (RX_SW_STROBE);
  probe_ack_c: cover property (probe_ack);
  load_error_c: cover property (txn_done && txn_loader && txn_err && !txn_probe);
endmodule // serial_cycle_control

// ### hdl/serial_sync2.sv
`timescale 1ns/1ns
module serial_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  // Clears to zero so the reset pins look asserted just after RST
  always_comb begin
    next_meta = d;
    next_q = meta;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule // serial_sync2

// ### shared/serial_pkg.sv
package serial_pkg;
  typedef enum logic [1:0] {BIT_START, BIT_STOP, BIT_DATA} bit_cmd_e;
  typedef enum logic [3:0] {S_IDLE, S_START, S_DEV, S_WORD, S_RESTART, S_RDEV, S_WDATA, S_RDATA, S_STOP} txn_state_e;
  typedef enum logic [2:0] {LD_OFF, LD_PROBE, LD_PROBE_WAIT, LD_READ, LD_READ_WAIT} load_state_e;
endpackage

// ### shared/serial_regs.svh
`ifndef SERIAL_REGS_SVH
`define SERIAL_REGS_SVH
// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define TARGET_ADDR_OFFSET 8'h46
`define CTRL_STATUS_OFFSET 8'h47
`define TARGET_ADDR_RESET 8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define DIR_BIT 0
`define ADDR_PHASE_BIT 7
`define RESERVED_BIT 6
`define SW_BUSY_BIT 5
`define LOAD_BUSY_BIT 4
`define PRESENT_BIT 3
`define FAST_CLOCK_BIT 2
`define SW_ERROR_BIT 1
`define LOAD_ERROR_BIT 0
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_RATE_KHZ 25000
`define NORMAL_SCL_KHZ 60
`define FAST_SCL_KHZ 4000
// Four phases per bit; rounding down keeps the bus no slower than nominal
`define NORMAL_QUARTER_CYC (`CLK_RATE_KHZ / (4 * `NORMAL_SCL_KHZ))
`define FAST_QUARTER_CYC (`CLK_RATE_KHZ / (4 * `FAST_SCL_KHZ))
`endif

// ### test/serial_target_model.sv
`timescale 1ns/1ns
// ----------------------------------------
// Two-wire target: acks its own address, logs word and data, answers reads
// ----------------------------------------
module serial_target_model #(
  parameter logic [6:0] ADDR = 7'h3a
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] rd_byte,
  output logic sda_low,
  output logic [7:0] word,
  output logic [7:0] data
);
  logic [7:0] sh;
  logic act = 0, rd = 0, hit = 0, tx = 0;
  int n = 0, k = 0;
  initial sda_low = 0;
  always @(negedge sda) if (scl) begin act = 1; n = 0; k = 0; tx = 0; end
  always @(posedge sda) if (scl) act = 0;
  always @(posedge scl) if (act && n < 8) begin sh = {sh[6:0], sda}; n++; end
  always @(negedge scl) if (act) begin
    if (n == 9) begin n = 0; tx = rd && hit; sda_low = tx && !rd_byte[7]; end
    else if (tx) begin
      // Released after the last bit so the host can send its no-ack
      sda_low = n < 8 && !rd_byte[7 - n];
      if (n == 8) begin n = 9; hit = 0; end
    end else if (n == 8) begin
      if (k == 0) begin hit = sh[7:1] == ADDR; rd = sh[0]; end
      else if (k == 1 && hit) word = sh;
      else if (hit) data = sh;
      sda_low = hit;
      k++;
      n = 9;
    end
  end
endmodule // serial_target_model

// ### test/tb.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("mismatch %s exp %h got %h", nm, e, g); end end
// ----------------------------------------
// Bench: fast clock mode keeps transactions short; the probe runs at normal rate
// ----------------------------------------
module tb;
  logic clk = 0, rst = 1, prst_n = 0, global_reset_n_n = 1, wen = 0, ren = 0, g4 = 0, g4e = 0, p;
  logic [7:0] addr = 0, wdat = 0, dat = 0, idx = 0, rbyte = 0, rdat, rxb, word, data, got, w_exp, lidx, li, ebyte;
  logic s4o, s4e, s5o, s5e, scl, sda, tlow, rxs, rxl, elow, een = 0;
  int miscompares = 0, tests_run = 0;
  always #20 clk = ~clk;
  assign scl = !(s4e && !s4o);
  assign sda = !((s5e && !s5o) || tlow || (elow && een));
  always @(posedge clk) if (rxs || rxl) begin got <= rxb; li <= lidx; end
  serial_cycle_control #(.LOAD_COUNT(2)) u_serial_cycle_control (.CLK(clk), .RST(rst), .PLATFORM_RESET_N(prst_n),
    .GLOBAL_RESET_N(global_reset_n_n), .REG_ADDR(addr), .REG_WR_EN(wen), .REG_WR_DATA(wdat), .REG_RD_EN(ren),
    .REG_RD_DATA(rdat), .DATA_BYTE(dat), .INDEX_BYTE(idx), .RX_BYTE(rxb), .RX_SW_STROBE(rxs),
    .RX_LOAD_STROBE(rxl), .LOAD_INDEX(lidx), .GP_FOUR_OUT(g4), .GP_FOUR_OE(g4e), .GP_FIVE_OUT(g4e),
    .GP_FIVE_OE(g4), .SHARED_PIN_FOUR_IN(scl), .SHARED_PIN_FOUR_OUT(s4o), .SHARED_PIN_FOUR_OE(s4e),
    .SHARED_PIN_FIVE_IN(sda), .SHARED_PIN_FIVE_OUT(s5o), .SHARED_PIN_FIVE_OE(s5e));
  serial_target_model u_serial_target_model (.scl(scl), .sda(sda), .rd_byte(rbyte), .sda_low(tlow),
    .word(word), .data(data));
  serial_target_model #(.ADDR(7'h50)) u_eeprom_model (.scl(scl), .sda(sda), .rd_byte(ebyte), .sda_low(elow),
    .word(), .data());
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk); #1 addr = a; wdat = d; wen = w; ren = !w;
    @(posedge clk); #1 wen = 0; ren = 0;
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 25000 && (i == 0 || rdat[5:4] !== 2'b00); i++) acc(8'h47, 0, 0);
    if (rdat[5:4] !== 2'b00) begin miscompares++; tally_and_finish; end
  endtask
  initial begin
    void'($urandom(32'hf671));
    repeat (12) @(posedge clk);
    #1 rst = 0; prst_n = 1;
    repeat (8) @(posedge clk);
    acc(8'h47, 0, 0); `CHK("probe busy", 8'h10, rdat)
    wait_idle; `CHK("no eeprom", 8'h00, rdat)
    acc(8'h46, 0, 0); `CHK("addr reset", 8'h00, rdat)
    acc(8'h40, 0, 0); `CHK("unmapped", 8'h00, rdat)
    acc(8'h47, 1, 8'hfc); acc(8'h47, 0, 0); `CHK("ctrl", 8'h8c, rdat)
    $display("test reset and control done");
    for (int r = 0; r < 4; r++) begin
      p = r[0];
      acc(8'h47, 1, 8'h0c); dat = 8'($urandom); idx = 8'($urandom); w_exp = idx;
      acc(8'h46, 1, {7'h3a, 1'b0}); acc(8'h47, 0, 0); `CHK("busy", 1'b1, rdat[5])
      wait_idle; `CHK("wr data", dat, data)
      `CHK("wr word", idx, word)
      `CHK("no err", 1'b0, rdat[1])
      acc(8'h47, 1, {p, 7'h0c}); rbyte = 8'($urandom); idx = 8'($urandom);
      if (!p) w_exp = idx;
      acc(8'h46, 1, {7'h3a, 1'b1}); wait_idle; `CHK("rd byte", rbyte, got)
      `CHK("rd word", w_exp, word)
      acc(8'h46, 0, 0); `CHK("addr rb", {7'h3a, 1'b1}, rdat)
      $display("test round %0d done", r);
    end
    acc(8'h47, 1, 8'h0c); acc(8'h46, 1, {7'h11, 1'b0}); wait_idle;
    `CHK("nack err", 1'b1, rdat[1])
    acc(8'h47, 1, 8'h0e); acc(8'h47, 0, 0); `CHK("err clear", 8'h0c, rdat)
    $display("test error done");
    global_reset_n_n = 0;
    repeat (4) @(posedge clk);
    #1 global_reset_n_n = 1;
    repeat (4) @(posedge clk);
    acc(8'h46, 0, 0); `CHK("fund reset", 8'h00, rdat)
    acc(8'h47, 0, 0); `CHK("no redetect", 8'h00, rdat)
    $display("test fundamental reset done");
    een = 1; ebyte = 8'($urandom); prst_n = 0;
    repeat (4) @(posedge clk);
    #1 prst_n = 1;
    repeat (8) @(posedge clk);
    wait_idle; `CHK("eeprom found", 8'h08, rdat)
    `CHK("load byte", ebyte, got)
    `CHK("load index", 8'h01, li)
    $display("test eeprom load done");
    acc(8'h47, 1, 8'h00); {g4e, g4} = 2'($urandom);
    repeat (3) @(posedge clk);
    #1 `CHK("gp pin", {g4e, g4, g4, g4e}, {s4e, s4o, s5e, s5o})
    $display("test pins done");
    tally_and_finish;
  end
endmodule // tb
